// File: core/tmss_pkg.sv
// Purpose: Shared constants for the master/slave timer synchronisation block
// Assumes: One peripheral clock, synchronous active-high reset
// Notes:   Mode and select encodings are 3-bit fields
package tmss_pkg;

  // ----------------------------------------
  // Field widths and encodings
  // ----------------------------------------
  localparam int          TMSS_CNT_W      = 16;
  localparam int          TMSS_PSC_W      = 16;
  localparam logic [2:0]  MMS_RESET       = 3'h0;
  localparam logic [2:0]  MMS_ENABLE      = 3'h1;
  localparam logic [2:0]  MMS_UPDATE      = 3'h2;
  localparam logic [2:0]  MMS_COMPARE1    = 3'h4;
  localparam logic [2:0]  TS_INTERNAL_TRIGGER_1         = 3'h1;
  localparam logic [2:0]  TS_CH1_EDGE     = 3'h4;
  localparam logic [2:0]  SMS_OFF         = 3'h0;
  localparam logic [2:0]  SMS_RESET       = 3'h4;
  localparam logic [2:0]  SMS_GATED       = 3'h5;
  localparam logic [2:0]  SMS_TRIGGER     = 3'h6;
  localparam logic [2:0]  SMS_EXT_CLOCK   = 3'h7;
  localparam logic [15:0] TMSS_CNT_RST    = 16'h0000;
  localparam logic [15:0] TMSS_PSC_RST    = 16'h0000;
  localparam logic [15:0] TMSS_ARR_RST    = 16'hFFFF;

endpackage

// File: core/tmss_sync2.sv
// Purpose: Two-flop synchroniser for one level from outside the clock domain
// Assumes: Single clock, synchronous active-high reset
// Notes:   First flop is read only by the second flop
`timescale 1ns/10ps
module tmss_sync2 (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_ff;

  // Two stages to settle metastability
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_ff <= 1'b0;
      sync_o  <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end

endmodule

// File: core/tmss_timer.sv
// Purpose: Timer core with master trigger output and slave trigger controller
// Assumes: One peripheral clock at 40 MHz, synchronous active-high reset
// Notes:   Internal trigger comes from a peer timer on the same clock
`timescale 1ns/10ps
module tmss_timer
  import tmss_pkg::*;
#(
  parameter int CNT_W = TMSS_CNT_W,
  parameter int PSC_W = TMSS_PSC_W
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic [2:0]       master_mode_select_i,
  input  wire logic [2:0]       trigger_input_select_i,
  input  wire logic [2:0]       slave_mode_select_i,
  input  wire logic             master_slave_delay_bit_i,
  input  wire logic             run_set_i,
  input  wire logic             run_clr_i,
  input  wire logic             update_generation_bit_i,
  input  wire logic             cnt_wr_i,
  input  wire logic [CNT_W-1:0] cnt_wdata_i,
  input  wire logic [PSC_W-1:0] psc_div_i,
  input  wire logic [CNT_W-1:0] reload_i,
  input  wire logic [CNT_W-1:0] compare1_i,
  input  wire logic             trig_flag_clr_i,
  input  wire logic             internal_trigger_1_i,
  input  wire logic             channel1_input_i,
  output logic                  trigger_out_o,
  output logic                  counter_run_bit_o,
  output logic                  counter_enable_internal_o,
  output logic [CNT_W-1:0]      count_o,
  output logic                  trigger_flag_o,
  output logic                  update_event_o,
  output logic                  compare1_reference_o
);

  // ----------------------------------------
  // Trigger input conditioning
  // ----------------------------------------
  logic ch1_sync;
  logic ch1_prev_ff;
  logic itr_prev_ff;
  logic trg_prev_ff;

  // Channel pin crosses into our clock before anyone looks at it
  tmss_sync2 u_ch1_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (channel1_input_i),
    .sync_o    (ch1_sync)
  );

  logic ch1_rise;
  logic itr_rise;
  logic sel_level;
  logic sel_rise;
  logic gate_level;

  // Peer trigger is same-clock logic, so no synchroniser
  assign ch1_rise  = ch1_sync & ~ch1_prev_ff;
  assign itr_rise  = internal_trigger_1_i & ~itr_prev_ff;
  assign sel_level = (trigger_input_select_i == TS_INTERNAL_TRIGGER_1)     ? internal_trigger_1_i :
                     (trigger_input_select_i == TS_CH1_EDGE) ? ch1_sync : 1'b0;
  assign sel_rise  = (trigger_input_select_i == TS_INTERNAL_TRIGGER_1)     ? itr_rise :
                     (trigger_input_select_i == TS_CH1_EDGE) ? ch1_rise : 1'b0;
  assign gate_level = sel_level;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ch1_prev_ff <= 1'b0;
      itr_prev_ff <= 1'b0;
    end else begin
      ch1_prev_ff <= ch1_sync;
      itr_prev_ff <= internal_trigger_1_i;
    end
  end

  // ----------------------------------------
  // Run bit and counter enable
  // ----------------------------------------
  logic run_ff;
  logic counter_enable_internal_d_ff;
  logic mode_trig;
  logic mode_gated;
  logic mode_ext;
  logic mode_reset;
  logic counter_enable_internal;
  logic nxt_run;

  assign mode_trig  = (slave_mode_select_i == SMS_TRIGGER);
  assign mode_gated = (slave_mode_select_i == SMS_GATED);
  assign mode_ext   = (slave_mode_select_i == SMS_EXT_CLOCK);
  assign mode_reset = (slave_mode_select_i == SMS_RESET);

  // Trigger sets the run bit; a same-cycle set wins over software clear
  assign nxt_run = (mode_trig & sel_rise) | run_set_i | (run_ff & ~run_clr_i);

  // Gate only qualifies enable; run bit low always holds it off
  assign counter_enable_internal = run_ff & (~mode_gated | gate_level);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      run_ff      <= 1'b0;
      counter_enable_internal_d_ff <= 1'b0;
    end else begin
      run_ff      <= nxt_run;
      counter_enable_internal_d_ff <= counter_enable_internal;
    end
  end

  // Delay lets slaves fed by our enable see the start on our first tick
  logic psc_en;
  assign psc_en = master_slave_delay_bit_i ? counter_enable_internal_d_ff : counter_enable_internal;

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  logic [PSC_W-1:0] psc_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             upd_ff;
  logic             psc_wrap;
  logic             tick;
  logic             at_reload;
  logic             reinit;

  // At-or-above, so lowering the divide mid-count cannot stall for a full wrap
  assign psc_wrap  = (psc_ff >= psc_div_i);
  // External clock mode counts trigger rises instead of prescaled ticks
  assign tick      = mode_ext ? (run_ff & sel_rise) : (psc_en & psc_wrap);
  assign at_reload = (cnt_ff == reload_i);
  // Software update or reset-mode trigger restarts from zero
  assign reinit    = update_generation_bit_i | (mode_reset & sel_rise);

  // Prescaler keeps its value across start and gate
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      psc_ff <= TMSS_PSC_RST[PSC_W-1:0];
    end else if (reinit) begin
      psc_ff <= TMSS_PSC_RST[PSC_W-1:0];
    end else if (psc_en & ~mode_ext) begin
      psc_ff <= psc_wrap ? TMSS_PSC_RST[PSC_W-1:0] : psc_ff + 1'b1;
    end
  end

  // Counter: software write, reinit, or advance on tick
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_ff <= TMSS_CNT_RST[CNT_W-1:0];
      upd_ff <= 1'b0;
    end else begin
      upd_ff <= reinit | (tick & at_reload);
      if (reinit) begin
        cnt_ff <= TMSS_CNT_RST[CNT_W-1:0];
      end else if (cnt_wr_i) begin
        cnt_ff <= cnt_wdata_i;
      end else if (tick) begin
        cnt_ff <= at_reload ? TMSS_CNT_RST[CNT_W-1:0] : cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Trigger flag
  // ----------------------------------------
  logic flag_ff;
  logic counter_enable_internal_prev_ff;
  logic flag_event;

  // Gated mode flags both enable edges; other modes except off flag the trigger
  assign flag_event = mode_gated ? (counter_enable_internal ^ counter_enable_internal_prev_ff)
                                 : (sel_rise & (slave_mode_select_i != SMS_OFF));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flag_ff        <= 1'b0;
      counter_enable_internal_prev_ff <= 1'b0;
    end else begin
      counter_enable_internal_prev_ff <= counter_enable_internal;
      flag_ff        <= flag_event | (flag_ff & ~trig_flag_clr_i);
    end
  end

  // ----------------------------------------
  // Master trigger output
  // ----------------------------------------
  logic compare1_reference_ff;
  logic trigger_out_ff;
  logic nxt_trigger_out;

  // Reference high while count is below compare value
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      compare1_reference_ff <= 1'b0;
    end else begin
      compare1_reference_ff <= (cnt_ff < compare1_i);
    end
  end

  // Mode decode; update is a one-cycle rise seen on the shared clock
  always_comb begin
    nxt_trigger_out = 1'b0;
    unique case (master_mode_select_i)
      MMS_RESET:  nxt_trigger_out = update_generation_bit_i;
      MMS_ENABLE: nxt_trigger_out = counter_enable_internal;
      MMS_UPDATE: nxt_trigger_out = reinit | (tick & at_reload);
      default:    nxt_trigger_out = master_mode_select_i[2] & compare1_reference_ff;
    endcase
  end

  // Gated slave stops once our run bit drops since the reference is masked
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trigger_out_ff <= 1'b0;
    end else begin
      trigger_out_ff <= nxt_trigger_out & (run_ff | ~master_mode_select_i[2]);
    end
  end

  assign trigger_out_o             = trigger_out_ff;
  assign counter_run_bit_o         = run_ff;
  assign counter_enable_internal_o = counter_enable_internal;
  assign count_o                   = cnt_ff;
  assign trigger_flag_o            = flag_ff;
  assign update_event_o            = upd_ff;
  assign compare1_reference_o      = compare1_reference_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Run bit, count and flag paths; the hold checks leave out the delayed
  // enable, which lets one last prescaler step through after a stop
  run_stop_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!run_ff && mode_gated && !master_slave_delay_bit_i && !reinit && !cnt_wr_i)
      |=> cnt_ff == $past(cnt_ff))
    else $error("gated counter ran with run bit low");
  trig_start_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_trig && sel_rise) |=> run_ff)
    else $error("trigger did not set run bit");
  ch1_trig_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (trigger_input_select_i == TS_CH1_EDGE && mode_trig && ch1_rise) |=> run_ff)
    else $error("channel edge did not start counter");
  ug_clear_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    update_generation_bit_i |=> (cnt_ff == '0 && psc_ff == '0))
    else $error("update generation did not clear");
  rst_mode_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_reset && sel_rise) |=> cnt_ff == '0)
    else $error("reset mode did not clear counter");
  gate_keep_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_gated && !counter_enable_internal && !master_slave_delay_bit_i && !reinit)
      |=> psc_ff == $past(psc_ff))
    else $error("gated prescaler moved while held");
  flag_set_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    flag_event |=> flag_ff)
    else $error("trigger flag missed an event");
  upd_trigger_out_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (master_mode_select_i == MMS_UPDATE && $stable(master_mode_select_i) && upd_ff)
      |-> trigger_out_ff)
    else $error("update not seen on trigger output");
  en_trigger_out_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (master_mode_select_i == MMS_ENABLE) |=> trigger_out_ff == $past(counter_enable_internal))
    else $error("enable not forwarded");
  ref_mask_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (master_mode_select_i[2] && !run_ff) |=> !trigger_out_ff)
    else $error("compare trigger not masked after stop");
  ext_clk_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_ext && run_ff && sel_rise && !reinit && !cnt_wr_i && !at_reload)
      |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("external clock edge not counted");
  gate_flag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_gated && $changed(counter_enable_internal)) |=> flag_ff)
    else $error("gate edge did not set flag");
  msm_delay_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    master_slave_delay_bit_i |-> psc_en == $past(counter_enable_internal))
    else $error("delayed prescaler enable mismatch");

  // Main scenarios the bench should reach
  gated_run_c: cover property (@(posedge clock_i) mode_gated && counter_enable_internal ##1 !counter_enable_internal);
  trig_run_c:  cover property (@(posedge clock_i) mode_trig && sel_rise ##1 run_ff);
  ext_tick_c:  cover property (@(posedge clock_i) mode_ext && tick);
  ch1_start_c: cover property (@(posedge clock_i) mode_trig && ch1_rise ##1 run_ff);
  ref_trigger_out_c:  cover property (@(posedge clock_i) master_mode_select_i[2] && trigger_out_ff);

endmodule

// File: testbench/tmss_peer.sv
// Purpose: Peer timer model that drives the internal trigger line
// Assumes: Same clock as the timer, synchronous active-high reset
// Notes:   Pulse every period+1 cycles, or a held level for gating
`timescale 1ns/10ps
module tmss_peer (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       en_i,
  input  wire logic       hold_i,
  input  wire logic [7:0] period_i,
  output logic            peer_trig_o
);
  logic [7:0] div_ff;

  // ----------------------------------------
  // Update-event stand-in
  // ----------------------------------------
  // Wrap counter paces the pulse train
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !en_i) div_ff <= 8'h00;
    else div_ff <= (div_ff == period_i) ? 8'h00 : div_ff + 8'h01;
  end

  // Registered, so the line only moves just after an edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) peer_trig_o <= 1'b0;
    else peer_trig_o <= hold_i | (en_i && div_ff == period_i);
  end
endmodule

// File: testbench/timer_master_slave_sync_tb_top.sv
// Purpose: Self-checking bench for the timer core against a peer model
// Assumes: 40 MHz clock, reset held for 20 cycles
// Notes:   Windows allow for the design's register and synchroniser stages
`timescale 1ns/10ps
module timer_master_slave_sync_tb_top;
  import tmss_pkg::*;
  // Master modes visited in order, lowest slice first
  localparam logic [14:0] MMS_SEQ = {3'h7, MMS_COMPARE1, MMS_ENABLE, MMS_RESET, MMS_UPDATE};
  logic        clock_i, sys_rst_i, msd, rs, rc, ug, wr, fclr, pin, pen, phold, watch;
  logic [2:0]  master_mode_select, ts, slave_mode_select;
  logic [15:0] wd, psc, rld, cmp, cnt, c0, p_cnt, pp_cnt;
  logic [7:0]  pper;
  logic        trg, run, cei, flg, update_event, c1r, ptrg, p_run, p_ug;
  int          failures, checks, seed, n;

  tmss_timer tmss_timer_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .master_mode_select_i(master_mode_select), .trigger_input_select_i(ts), .slave_mode_select_i(slave_mode_select),
    .master_slave_delay_bit_i(msd), .run_set_i(rs), .run_clr_i(rc),
    .update_generation_bit_i(ug), .cnt_wr_i(wr), .cnt_wdata_i(wd), .psc_div_i(psc),
    .reload_i(rld), .compare1_i(cmp), .trig_flag_clr_i(fclr),
    .internal_trigger_1_i(ptrg), .channel1_input_i(pin), .trigger_out_o(trg),
    .counter_run_bit_o(run), .counter_enable_internal_o(cei), .count_o(cnt),
    .trigger_flag_o(flg), .update_event_o(update_event), .compare1_reference_o(c1r));
  tmss_peer tmss_peer_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .en_i(pen),
    .hold_i(phold), .period_i(pper), .peer_trig_o(ptrg));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] adv(input logic [15:0] b, input int k);
    return b + 16'(k);
  endfunction
  // One-cycle control pulse: 0 run set, 1 run clear, 2 reinit, 3 write, 4 flag clear
  task automatic pulse(input int k);
    step(1);
    case (k)
      0: rs <= 1'b1;
      1: rc <= 1'b1;
      2: ug <= 1'b1;
      3: wr <= 1'b1;
      default: fclr <= 1'b1;
    endcase
    step(1);
    {rs, rc, ug, wr, fclr} <= 5'h00;
  endtask
  task automatic wait_run;
    for (int i = 0; i < 10 && run !== 1'b1; i++) begin
      step(1);
      #1;
    end
  endtask
  task report_and_stop;
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Outputs against a one- and two-cycle history, read mid-cycle where settled
  always @(negedge clock_i) begin
    if (watch) begin
      check(16'(update_event), 16'(p_ug | (p_run & p_cnt == rld)));
      check(16'(c1r), 16'(p_cnt < cmp));
      check(16'(cei), 16'(run));
      if (master_mode_select == MMS_UPDATE) check(16'(trg), 16'(p_ug | (p_run & p_cnt == rld)));
      if (master_mode_select == MMS_RESET) check(16'(trg), 16'(p_ug));
      if (master_mode_select == MMS_ENABLE) check(16'(trg), 16'(p_run));
      if (master_mode_select[2]) check(16'(trg), 16'(p_run & (pp_cnt < cmp)));
    end
    p_cnt  <= cnt;
    pp_cnt <= p_cnt;
    p_run  <= run;
    p_ug   <= ug;
  end

  initial begin
    step(20000);
    failures++;
    report_and_stop;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 32'h99C8A03B;
    sys_rst_i = 1'b1;
    {msd, rs, rc, ug, wr, fclr, pin, pen, phold, watch} = 10'h000;
    {master_mode_select, ts, slave_mode_select} = 9'h000;
    {wd, psc, cmp} = 48'h0;
    rld = 16'hFFFF;
    pper = 8'h03;
    step(20);
    sys_rst_i <= 1'b0;
    step(1);
    #1;
    check({12'h000, run, flg, update_event, trg}, 16'h0000);
    check(cnt, TMSS_CNT_RST);
    // Random start offset, then free run and reinit
    step(1);
    wd <= 16'($random(seed)) & 16'h7FFF;
    pulse(3);
    #1;
    check(cnt, wd);
    pulse(0);
    #1;
    check(cnt, wd);
    c0 = cnt;
    step(10);
    #1;
    check(cnt, adv(c0, 10));
    pulse(2);
    #1;
    check(cnt, 16'h0000);
    // Trigger start from the peer keeps the count
    pulse(1);
    slave_mode_select <= SMS_TRIGGER;
    ts <= TS_INTERNAL_TRIGGER_1;
    pulse(4);
    c0 = cnt;
    step(1);
    phold <= 1'b1;
    step(1);
    phold <= 1'b0;
    wait_run;
    check(16'(run), 16'h0001);
    check(16'(flg), 16'h0001);
    check(16'(cnt - c0 <= 16'h0001), 16'h0001);
    pulse(1);
    #1;
    check(16'(run), 16'h0000);
    // Peer pulses act as the counter clock
    step(1);
    slave_mode_select <= SMS_EXT_CLOCK;
    pulse(0);
    pper <= 8'(1 + ($unsigned($random(seed)) % 6));
    c0 = cnt;
    n = 0;
    pen <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      step(1);
      if (i == 40) pen <= 1'b0;
      #1;
      n += int'(ptrg);
    end
    check(cnt, adv(c0, n));
    // Gated: held level counts only with the run bit set
    pulse(1);
    slave_mode_select <= SMS_GATED;
    psc <= 16'h0001;
    phold <= 1'b1;
    c0 = cnt;
    step(12);
    #1;
    check(cnt, c0);
    pulse(4);
    pulse(0);
    c0 = cnt;
    step(16);
    #1;
    check(16'(cnt - c0 >= 16'h0006 && cnt - c0 <= 16'h0009), 16'h0001);
    check(16'(flg), 16'h0001);
    pulse(4);
    phold <= 1'b0;
    step(4);
    #1;
    c0 = cnt;
    step(10);
    #1;
    check(cnt, c0);
    check(16'(flg), 16'h0001);
    // Reset mode clears a running count
    step(1);
    slave_mode_select <= SMS_RESET;
    psc <= 16'h0000;
    wd <= 16'h8000;
    pulse(3);
    step(2);
    phold <= 1'b1;
    step(1);
    phold <= 1'b0;
    step(4);
    #1;
    check(16'(cnt < 16'h0008), 16'h0001);
    // Channel pin edge starts a delayed master
    pulse(1);
    {slave_mode_select, ts, msd} <= {SMS_TRIGGER, TS_CH1_EDGE, 1'b1};
    pulse(4);
    step(1);
    pin <= 1'b1;
    wait_run;
    check(16'(run), 16'h0001);
    check(16'(flg), 16'h0001);
    step(1);
    {pin, slave_mode_select, ts, msd} <= 8'h00;
    // Master output modes under a short period
    rld <= 16'h0009;
    cmp <= 16'(1 + ($unsigned($random(seed)) % 8));
    pulse(2);
    for (int i = 0; i < 5; i++) begin
      step(1);
      master_mode_select <= MMS_SEQ[i*3+:3];
      step(2);
      watch <= 1'b1;
      step(25);
      if (master_mode_select == MMS_RESET) pulse(2);
      else if (master_mode_select != MMS_UPDATE) pulse(1);
      step(3);
      if (master_mode_select != MMS_UPDATE && master_mode_select != MMS_RESET) pulse(0);
      step(5);
      watch <= 1'b0;
    end
    report_and_stop;
  end
endmodule
